/* logic/idc_pkg.sv */
// Constants, field layouts and carrier types for the dual current DAC update control.
// Summary of operation
// - Source code 111, the reset default, latches the held word on each high-byte write.
// - In write mode a low-byte write is only stored; the next high-byte write latches both.
// - Sources 000 to 011 latch the held word only on timer 0 to 3 overflow.
// - Timer 2 or 3 triggers on low-byte overflow in 8-bit mode, high-byte in 16-bit.
// - Source 100 takes a rising strobe edge, 101 a falling edge, 110 either edge.
// - Strobe modes hold both data bytes until the selected edge, then latch them.
// - Left justified: code 11..4 from high byte 7..0, code 3..0 from low byte 7..4.
// - Right justified: code 11..8 from high byte 3..0, code 7..0 from low byte.
// - Control bit 2 selects justification: 0 left, 1 right.
// - Control bits 1:0 pick full scale 0.25, 0.5, 1.0, 2.0 mA; reset is 2.0 mA.
// - Control bit 7 enables each channel on its own.
// - Control bit 3 is reserved: reads zero, software writes zero.
// - Both enables low leaves pins as GPIO; otherwise the selected pin goes analog.
// - Both enabled with merge select set puts both outputs on the first pin.
// - The bias generator enable is asserted while either channel is enabled.
// - Merge select 0 sends channel 1 to its own pin, 1 to the first pin.
package idc_pkg;

	localparam int ADDR_W = 12;
	localparam int IDX_W  = 10;
	localparam int CODE_W = 12;

	// Register indices; byte address is four times the index.
	localparam logic [IDX_W-1:0] IDX_DAC0_LOW   = 10'h096;
	localparam logic [IDX_W-1:0] IDX_DAC0_HIGH  = 10'h097;
	localparam logic [IDX_W-1:0] IDX_DAC1_CTRL  = 10'h0b5;
	localparam logic [IDX_W-1:0] IDX_DAC0_CTRL  = 10'h0b9;
	localparam logic [IDX_W-1:0] IDX_DAC1_LOW   = 10'h0f4;
	localparam logic [IDX_W-1:0] IDX_DAC1_HIGH  = 10'h0f5;
	localparam logic [IDX_W-1:0] IDX_DAC0_CODE  = 10'h100;
	localparam logic [IDX_W-1:0] IDX_DAC1_CODE  = 10'h101;

	localparam logic [7:0] CTRL_RESET = 8'h73;
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam logic [7:0] CTRL_WMASK = 8'hf7;
	localparam logic [CODE_W-1:0] CODE_RESET = 12'h000;

	typedef enum logic [2:0] {
		SRC_TIMER0  = 3'b000,
		SRC_TIMER1  = 3'b001,
		SRC_TIMER2  = 3'b010,
		SRC_TIMER3  = 3'b011,
		SRC_RISE    = 3'b100,
		SRC_FALL    = 3'b101,
		SRC_ANYEDGE = 3'b110,
		SRC_WRITE   = 3'b111
	} idc_source_e;

	typedef struct packed {
		logic        channel_enable;
		logic [2:0]  update_source_select;
		logic        reserved;
		logic        right_justify_select;
		logic [1:0]  full_scale_select;
	} idc_ctrl_s;

	typedef struct packed {
		logic              enable;
		logic [1:0]        full_scale;
		logic [CODE_W-1:0] code;
	} idc_chan_s;

	typedef struct packed {
		logic t0_overflow;
		logic t1_overflow;
		logic t2_low_overflow;
		logic t2_high_overflow;
		logic t2_split_8bit;
		logic t3_low_overflow;
		logic t3_high_overflow;
		logic t3_split_8bit;
	} idc_timer_s;

endpackage

/* logic/idc_top.sv */
// Two-channel current DAC register file, update triggers and pin routing.
`timescale 1ns/1ps
module idc_top
	import idc_pkg::*;
(
	// Clock and reset.
	input  wire logic                clock,
	input  wire logic                rst,
	// APB slave.
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [ADDR_W-1:0]   paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	// Update triggers.
	input  wire idc_timer_s          timers,
	input  wire logic                conversion_strobe_pin,
	// Reference control merge bit.
	input  wire logic                output_merge_select,
	// Converter and pin control.
	output idc_chan_s [1:0]          chan,
	output logic      [1:0]          pin_analog_select,
	output logic                     dac1_on_pin0,
	output logic                     bias_enable
);

	// APB decode.
	wire logic             setup_phase = psel & ~penable;
	wire logic             access_wr   = psel & penable & pwrite;
	wire logic [IDX_W-1:0] idx         = paddr[ADDR_W-1:2];
	wire logic             addr_mapped = (idx == IDX_DAC0_LOW) | (idx == IDX_DAC0_HIGH)
		| (idx == IDX_DAC1_CTRL) | (idx == IDX_DAC0_CTRL) | (idx == IDX_DAC1_LOW)
		| (idx == IDX_DAC1_HIGH) | (idx == IDX_DAC0_CODE) | (idx == IDX_DAC1_CODE);

	// Strobe pin synchroniser and edge detection.
	logic strobe_meta;
	logic strobe_sync;
	logic strobe_prev;
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			strobe_meta <= 1'b0;
			strobe_sync <= 1'b0;
			strobe_prev <= 1'b0;
		end
		else
		begin
			strobe_meta <= conversion_strobe_pin;
			strobe_sync <= strobe_meta;
			strobe_prev <= strobe_sync;
		end
	end
	wire logic strobe_rise = strobe_sync & ~strobe_prev;
	wire logic strobe_fall = ~strobe_sync & strobe_prev;

	// Timer 2 and 3 follow their own width mode.
	wire logic t2_event = timers.t2_split_8bit ? timers.t2_low_overflow
		: timers.t2_high_overflow;
	wire logic t3_event = timers.t3_split_8bit ? timers.t3_low_overflow
		: timers.t3_high_overflow;

	idc_ctrl_s         ctrl       [2];
	logic [7:0]        data_low   [2];
	logic [7:0]        data_high  [2];
	logic [7:0]        read_low   [2];
	logic [7:0]        read_high  [2];
	logic [CODE_W-1:0] next_word  [2];
	logic              trigger    [2];
	logic              low_wr     [2];
	logic              high_wr    [2];
	logic [CODE_W-1:0] code_q     [2];

	genvar c;
	generate
		for (c = 0; c < 2; c++)
		begin : g_chan
			wire logic [IDX_W-1:0] idx_low  = (c == 0) ? IDX_DAC0_LOW  : IDX_DAC1_LOW;
			wire logic [IDX_W-1:0] idx_high = (c == 0) ? IDX_DAC0_HIGH : IDX_DAC1_HIGH;
			wire logic [IDX_W-1:0] idx_ctrl = (c == 0) ? IDX_DAC0_CTRL : IDX_DAC1_CTRL;
			wire logic             ctrl_wr  = access_wr & (idx == idx_ctrl);
			assign low_wr[c]  = access_wr & (idx == idx_low);
			assign high_wr[c] = access_wr & (idx == idx_high);

			// A write in the same cycle as a trigger is included in the latched word.
			wire logic [7:0] next_low  = low_wr[c]  ? pwdata[7:0] : data_low[c];
			wire logic [7:0] next_high = high_wr[c] ? pwdata[7:0] : data_high[c];
			wire logic       rjust     = ctrl[c].right_justify_select;
			assign next_word[c] = rjust ? {next_high[3:0], next_low}
				: {next_high, next_low[7:4]};

			// Unused positions read as zero under the present justification.
			assign read_low[c]  = rjust ? data_low[c] : {data_low[c][7:4], 4'h0};
			assign read_high[c] = rjust ? {4'h0, data_high[c][3:0]} : data_high[c];

			always_comb
			begin
				unique case (idc_source_e'(ctrl[c].update_source_select))
					SRC_TIMER0:  trigger[c] = timers.t0_overflow;
					SRC_TIMER1:  trigger[c] = timers.t1_overflow;
					SRC_TIMER2:  trigger[c] = t2_event;
					SRC_TIMER3:  trigger[c] = t3_event;
					SRC_RISE:    trigger[c] = strobe_rise;
					SRC_FALL:    trigger[c] = strobe_fall;
					SRC_ANYEDGE: trigger[c] = strobe_rise | strobe_fall;
					SRC_WRITE:   trigger[c] = high_wr[c];
				endcase
			end

			always_ff @(posedge clock or posedge rst)
			begin
				if (rst)
				begin
					ctrl[c]      <= CTRL_RESET;
					data_low[c]  <= DATA_RESET;
					data_high[c] <= DATA_RESET;
					code_q[c]    <= CODE_RESET;
				end
				else
				begin
					if (ctrl_wr)
						ctrl[c] <= pwdata[7:0] & CTRL_WMASK;
					data_low[c]  <= next_low;
					data_high[c] <= next_high;
					if (trigger[c])
						code_q[c] <= next_word[c];
				end
			end

			// The channel word has a single driver, so no field mixes flops and assigns.
			assign chan[c] = {ctrl[c].channel_enable, ctrl[c].full_scale_select,
				code_q[c]};
		end
	endgenerate

	// Pin takeover and merging.
	assign bias_enable  = chan[0].enable | chan[1].enable;
	assign dac1_on_pin0 = chan[1].enable & output_merge_select;
	assign pin_analog_select[0] = chan[0].enable | dac1_on_pin0;
	assign pin_analog_select[1] = chan[1].enable & ~output_merge_select;

	// Read data is captured in the setup cycle so the access phase needs no wait state.
	logic [31:0] read_value;
	always_comb
	begin
		read_value = 32'h0000_0000;
		unique case (idx)
			IDX_DAC0_LOW:  read_value[7:0] = read_low[0];
			IDX_DAC0_HIGH: read_value[7:0] = read_high[0];
			IDX_DAC0_CTRL: read_value[7:0] = ctrl[0];
			IDX_DAC1_LOW:  read_value[7:0] = read_low[1];
			IDX_DAC1_HIGH: read_value[7:0] = read_high[1];
			IDX_DAC1_CTRL: read_value[7:0] = ctrl[1];
			IDX_DAC0_CODE: read_value[CODE_W-1:0] = chan[0].code;
			IDX_DAC1_CODE: read_value[CODE_W-1:0] = chan[1].code;
			default:       read_value = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else if (setup_phase)
		begin
			prdata  <= pwrite ? 32'h0000_0000 : read_value;
			pslverr <= ~addr_mapped;
		end
	end
	assign pready = 1'b1;

	// Checks.
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	property p_write_latch;
		high_wr[0] && ctrl[0].update_source_select == SRC_WRITE && !ctrl[0].right_justify_select
			|=> chan[0].code[11:4] == $past(pwdata[7:0]);
	endproperty
	a_write_latch: assert property (p_write_latch) else $error("high write did not latch");

	property p_low_hold;
		low_wr[0] && ctrl[0].update_source_select == SRC_WRITE |=> $stable(chan[0].code);
	endproperty
	a_low_hold: assert property (p_low_hold) else $error("low write changed output");

	property p_timer_hold;
		ctrl[0].update_source_select == SRC_TIMER0 && !timers.t0_overflow
			|=> $stable(chan[0].code);
	endproperty
	a_timer_hold: assert property (p_timer_hold) else $error("code moved without overflow");

	property p_t2_split;
		ctrl[0].update_source_select == SRC_TIMER2 && timers.t2_split_8bit
			&& !timers.t2_low_overflow |=> $stable(chan[0].code);
	endproperty
	a_t2_split: assert property (p_t2_split) else $error("timer 2 mode trigger wrong");

	property p_strobe_rise;
		ctrl[0].update_source_select == SRC_RISE && $rose(strobe_sync)
			|=> chan[0].code == $past(next_word[0]);
	endproperty
	a_strobe_rise: assert property (p_strobe_rise) else $error("rising edge not latched");

	property p_strobe_hold;
		ctrl[0].update_source_select == SRC_FALL && !$fell(strobe_sync)
			|=> $stable(chan[0].code);
	endproperty
	a_strobe_hold: assert property (p_strobe_hold) else $error("held data leaked");

	property p_rjust_read;
		setup_phase && !pwrite && idx == IDX_DAC1_HIGH && ctrl[1].right_justify_select
			|=> prdata[7:4] == 4'h0;
	endproperty
	a_rjust_read: assert property (p_rjust_read) else $error("unused bits not zero");

	property p_reserved;
		access_wr && idx == IDX_DAC1_CTRL ##[1:2] setup_phase && !pwrite && idx == IDX_DAC1_CTRL
			|=> prdata[3] == 1'b0;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bit read back");

	property p_bias;
		access_wr && idx == IDX_DAC1_CTRL && pwdata[7] |=> bias_enable && chan[1].enable;
	endproperty
	a_bias: assert property (p_bias) else $error("bias not enabled");

	property p_merge;
		chan[0].enable && chan[1].enable && output_merge_select
			|-> dac1_on_pin0 && !pin_analog_select[1] && pin_analog_select[0];
	endproperty
	a_merge: assert property (p_merge) else $error("merge routing wrong");

	property p_gpio;
		!chan[0].enable && !chan[1].enable |-> pin_analog_select == 2'b00;
	endproperty
	a_gpio: assert property (p_gpio) else $error("pin taken while disabled");

	property p_hold_write;
		ctrl[0].update_source_select == SRC_WRITE && !high_wr[0] |=> $stable(chan[0].code);
	endproperty
	a_hold_write: assert property (p_hold_write) else $error("code moved in write mode");

	property p_low_store;
		low_wr[0] |=> data_low[0] == $past(pwdata[7:0]);
	endproperty
	a_low_store: assert property (p_low_store) else $error("low byte not stored");

	property p_left_low;
		high_wr[0] && ctrl[0].update_source_select == SRC_WRITE && !ctrl[0].right_justify_select
			|=> chan[0].code[3:0] == $past(data_low[0][7:4]);
	endproperty
	a_left_low: assert property (p_left_low) else $error("left low nibble wrong");

	property p_right_latch;
		high_wr[1] && ctrl[1].update_source_select == SRC_WRITE && ctrl[1].right_justify_select
			|=> chan[1].code == {$past(pwdata[3:0]), $past(data_low[1])};
	endproperty
	a_right_latch: assert property (p_right_latch) else $error("right word wrong");

	// Channel 1 right justified while channel 0 stays left shows the bits are not shared.
	property p_own_justify;
		high_wr[1] && ctrl[1].update_source_select == SRC_WRITE
			&& ctrl[1].right_justify_select && !ctrl[0].right_justify_select
			|=> chan[1].code[11:8] == $past(pwdata[3:0]);
	endproperty
	a_own_justify: assert property (p_own_justify) else $error("shared justify");

	property p_t0_fire;
		ctrl[0].update_source_select == SRC_TIMER0 && timers.t0_overflow
			|=> chan[0].code == $past(next_word[0]);
	endproperty
	a_t0_fire: assert property (p_t0_fire) else $error("timer 0 missed");

	property p_t1_fire;
		ctrl[0].update_source_select == SRC_TIMER1 && timers.t1_overflow
			|=> chan[0].code == $past(next_word[0]);
	endproperty
	a_t1_fire: assert property (p_t1_fire) else $error("timer 1 missed");

	property p_t1_hold;
		ctrl[0].update_source_select == SRC_TIMER1 && !timers.t1_overflow
			|=> $stable(chan[0].code);
	endproperty
	a_t1_hold: assert property (p_t1_hold) else $error("timer 1 hold broken");

	property p_t2_wide;
		ctrl[0].update_source_select == SRC_TIMER2 && !timers.t2_split_8bit
			&& timers.t2_high_overflow |=> chan[0].code == $past(next_word[0]);
	endproperty
	a_t2_wide: assert property (p_t2_wide) else $error("timer 2 wide missed");

	property p_t2_wide_hold;
		ctrl[0].update_source_select == SRC_TIMER2 && !timers.t2_split_8bit
			&& !timers.t2_high_overflow |=> $stable(chan[0].code);
	endproperty
	a_t2_wide_hold: assert property (p_t2_wide_hold) else $error("timer 2 wide leak");

	property p_t3_split;
		ctrl[0].update_source_select == SRC_TIMER3 && timers.t3_split_8bit
			&& timers.t3_low_overflow |=> chan[0].code == $past(next_word[0]);
	endproperty
	a_t3_split: assert property (p_t3_split) else $error("timer 3 split missed");

	property p_t3_split_hold;
		ctrl[0].update_source_select == SRC_TIMER3 && timers.t3_split_8bit
			&& !timers.t3_low_overflow |=> $stable(chan[0].code);
	endproperty
	a_t3_split_hold: assert property (p_t3_split_hold) else $error("timer 3 leak");

	property p_strobe_fall;
		ctrl[0].update_source_select == SRC_FALL && $fell(strobe_sync)
			|=> chan[0].code == $past(next_word[0]);
	endproperty
	a_strobe_fall: assert property (p_strobe_fall) else $error("falling edge missed");

	property p_any_edge;
		ctrl[0].update_source_select == SRC_ANYEDGE && $changed(strobe_sync)
			|=> chan[0].code == $past(next_word[0]);
	endproperty
	a_any_edge: assert property (p_any_edge) else $error("edge missed");

	property p_rise_hold;
		ctrl[0].update_source_select == SRC_RISE && !$rose(strobe_sync)
			|=> $stable(chan[0].code);
	endproperty
	a_rise_hold: assert property (p_rise_hold) else $error("rise mode leaked");

	property p_justify_read;
		setup_phase && !pwrite && idx == IDX_DAC0_HIGH && !ctrl[0].right_justify_select
			|=> prdata[7:0] == $past(data_high[0]);
	endproperty
	a_justify_read: assert property (p_justify_read) else $error("left high read wrong");

	property p_left_read;
		setup_phase && !pwrite && idx == IDX_DAC0_LOW && !ctrl[0].right_justify_select
			|=> prdata[3:0] == 4'h0;
	endproperty
	a_left_read: assert property (p_left_read) else $error("unused low bits set");

	property p_full_scale;
		access_wr && idx == IDX_DAC0_CTRL |=> chan[0].full_scale == $past(pwdata[1:0]);
	endproperty
	a_full_scale: assert property (p_full_scale) else $error("full scale wrong");

	property p_enable_own;
		access_wr && idx == IDX_DAC0_CTRL
			|=> chan[0].enable == $past(pwdata[7]) && $stable(chan[1].enable);
	endproperty
	a_enable_own: assert property (p_enable_own) else $error("enable not independent");

	property p_reserved_state;
		!ctrl[0].reserved && !ctrl[1].reserved;
	endproperty
	a_reserved_state: assert property (p_reserved_state) else $error("reserved bit set");

	property p_takeover;
		chan[0].enable |-> pin_analog_select[0];
	endproperty
	a_takeover: assert property (p_takeover) else $error("pin 0 not taken");

	property p_own_pin;
		chan[1].enable && !output_merge_select |-> pin_analog_select[1] && !dac1_on_pin0;
	endproperty
	a_own_pin: assert property (p_own_pin) else $error("channel 1 pin wrong");

	property p_bias_off;
		!chan[0].enable && !chan[1].enable |-> !bias_enable;
	endproperty
	a_bias_off: assert property (p_bias_off) else $error("bias on while idle");

	c_write_mode: cover property (high_wr[0] && ctrl[0].update_source_select == SRC_WRITE);
	c_timer3: cover property (ctrl[0].update_source_select == SRC_TIMER3 && t3_event);
	c_any_edge: cover property (ctrl[0].update_source_select == SRC_ANYEDGE && strobe_fall);
	c_merged: cover property (dac1_on_pin0 && chan[0].enable);

endmodule

/* test/idc_far_model.sv */
// Timer overflow and conversion strobe source facing the update triggers.
`timescale 1ns/1ps
module idc_far_model
	import idc_pkg::*;
(
	// Clock.
	input  wire logic  clock,
	// Trigger outputs.
	output idc_timer_s timers,
	output logic       conversion_strobe_pin
);
	logic [7:0] ovf = 8'h00;
	logic [1:0] split = 2'b00;
	initial conversion_strobe_pin = 1'b0;
	// Split flags are levels, so the overflow mask never drives their positions.
	assign timers = idc_timer_s'((ovf & 8'hf6) | {4'h0, split[0], 2'h0, split[1]});
	// Overflows are single-cycle pulses in the system clock domain.
	task pulse(input logic [1:0] s, input logic [7:0] m);
		@(posedge clock);
		split <= s;
		ovf <= m;
		@(posedge clock);
		ovf <= 8'h00;
	endtask
	task edge_to(input logic lv);
		@(posedge clock);
		conversion_strobe_pin <= lv;
	endtask
endmodule

/* test/test_dual_current_dac_update_control.sv */
// Self-checking bench for the dual current DAC update control.
`timescale 1ns/1ps
module test_dual_current_dac_update_control;
	import idc_pkg::*;
	localparam logic [11:0] A_L0 = {IDX_DAC0_LOW, 2'b00};
	localparam logic [11:0] A_H0 = {IDX_DAC0_HIGH, 2'b00};
	localparam logic [11:0] A_C0 = {IDX_DAC0_CTRL, 2'b00};
	localparam logic [11:0] A_C1 = {IDX_DAC1_CTRL, 2'b00};
	localparam logic [11:0] A_L1 = {IDX_DAC1_LOW, 2'b00};
	localparam logic [11:0] A_H1 = {IDX_DAC1_HIGH, 2'b00};
	localparam logic [11:0] AZ [6] = '{A_L0, A_H0, A_L1, A_H1, 12'h400, 12'h404};
	localparam logic [7:0]  TM [6] = '{8'h80, 8'h40, 8'h10, 8'h02, 8'h20, 8'h04};
	logic            clock = 0;
	logic            rst = 1;
	logic            psel = 0;
	logic            penable = 0;
	logic            pwrite = 0;
	logic            output_merge_select = 0;
	logic            sflag = 0;
	logic [11:0]     paddr = 0;
	logic [31:0]     pwdata = 0;
	logic [31:0]     prdata;
	logic            pready;
	logic            pslverr;
	logic            dac1_on_pin0;
	logic            bias_enable;
	logic [1:0]      pin_analog_select;
	idc_timer_s      timers;
	logic            conversion_strobe_pin;
	idc_chan_s [1:0] chan;
	logic [33:0]     q[$];
	int              n_errors = 0;
	int              n_compared = 0;
	integer          seed = 32'he438;
	logic [7:0]      c0 = 8'h73;
	logic [7:0]      c1 = 8'h73;
	logic [7:0]      lo;
	logic [7:0]      hi;
	logic [11:0]     k0 = 0;
	logic [11:0]     k1 = 0;
	logic [2:0]      src;
	logic [1:0]      sp;
	logic            lv;

	always #5 clock = ~clock;

	idc_top idc_top_inst (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .timers(timers), .conversion_strobe_pin(conversion_strobe_pin),
		.output_merge_select(output_merge_select), .chan(chan),
		.pin_analog_select(pin_analog_select), .dac1_on_pin0(dac1_on_pin0),
		.bias_enable(bias_enable));
	idc_far_model idc_far_model_inst (.clock(clock), .timers(timers),
		.conversion_strobe_pin(conversion_strobe_pin));

	task close_out;
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task cmp(input logic [33:0] got);
		logic [33:0] e;
		e = (q.size() > 0) ? q.pop_front() : ~got;
		n_compared++;
		if (got !== e)
		begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, e);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		int n;
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'($random(seed)), d};
		@(posedge clock);
		penable <= 1'b1;
		for (n = 0; n < 8; n++)
		begin
			@(posedge clock);
			if (pready === 1'b1)
				break;
		end
		if (n == 8)
		begin
			n_errors++;
			close_out();
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [11:0] a, input logic [7:0] d);
		apb(1'b1, a, d);
	endtask
	task rd(input logic [11:0] a, input logic [32:0] e);
		q.push_back({1'b0, e});
		apb(1'b0, a, 8'h00);
	endtask
	// The edge first lets any input change land before the expectation reads it.
	task chk;
		@(posedge clock);
		q.push_back({c1[7], c1[1:0], k1, c0[7], c0[1:0], k0, c0[7] | c1[7],
			c1[7] & output_merge_select, c1[7] & ~output_merge_select,
			c0[7] | (c1[7] & output_merge_select)});
		sflag <= 1'b1;
		@(posedge clock);
		sflag <= 1'b0;
	endtask
	task newdata;
		lo = 8'($random(seed));
		hi = 8'($random(seed));
	endtask

	always @(posedge clock)
	begin
		if (psel && penable && pready && !pwrite)
			cmp({1'b0, pslverr, prdata});
		if (sflag)
			cmp({chan, bias_enable, dac1_on_pin0, pin_analog_select});
	end

	initial
	begin
		repeat (20000) @(posedge clock);
		n_errors++;
		close_out();
	end

	initial
	begin
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		rd(A_C0, 33'h73);
		rd(A_C1, 33'h73);
		foreach (AZ[i])
			rd(AZ[i], 33'h0);
		rd(12'h000, 33'h1_0000_0000);
		chk();
		newdata();
		wr(A_L0, lo);
		chk();
		wr(A_H0, hi);
		k0 = {hi, lo[7:4]};
		chk();
		rd(A_L0, {25'h0, lo[7:4], 4'h0});
		hi = 8'($random(seed));
		wr(A_H0, hi);
		k0 = {hi, lo[7:4]};
		chk();
		wr(A_C1, 8'hf4);
		c1 = 8'hf4;
		rd(A_C1, {25'h0, c1});
		newdata();
		wr(A_L1, lo);
		wr(A_H1, hi);
		k1 = {hi[3:0], lo};
		chk();
		rd(A_H1, {29'h0, hi[3:0]});
		output_merge_select <= 1'b1;
		// Skip bits live in the crossbar; the bench checks the takeover they pair with.
		chk();
		wr(A_C0, 8'hf3);
		c0 = 8'hf3;
		chk();
		output_merge_select <= 1'b0;
		for (int i = 0; i < 6; i++)
		begin
			src = (i < 4) ? 3'(i) : 3'(i - 2);
			sp = (i >= 4) ? 2'b11 : 2'b00;
			c0 = {i[0], src, 2'b00, 2'(i)};
			wr(A_C0, c0);
			newdata();
			wr(A_L0, lo);
			wr(A_H0, hi);
			idc_far_model_inst.pulse(sp, 8'hf6 & ~TM[i]);
			chk();
			idc_far_model_inst.pulse(sp, TM[i]);
			k0 = {hi, lo[7:4]};
			chk();
		end
		for (int i = 0; i < 6; i++)
		begin
			src = 3'(4 + i / 2);
			lv = ~i[0];
			c0 = {1'b1, src, 4'h3};
			if (i[0] == 1'b0)
				wr(A_C0, c0);
			newdata();
			wr(A_L0, lo);
			wr(A_H0, hi);
			idc_far_model_inst.edge_to(lv);
			repeat (6) @(posedge clock);
			if (src == SRC_ANYEDGE || (src == SRC_RISE) == lv)
				k0 = {hi, lo[7:4]};
			chk();
		end
		close_out();
	end
endmodule
